// [hw/bcast_filter_map.vh]
// Constants shared by the broadcast frame filter: command layout, frame offsets, register map.
`ifndef BCAST_FILTER_MAP_VH
`define BCAST_FILTER_MAP_VH

// ----------------------------------------------------------------------------
// Command packet layout
// ----------------------------------------------------------------------------
`define CMD_TYPE_ENABLE_BCAST  8'h10
`define RESP_TYPE_ENABLE_BCAST 8'h90
`define CMD_TYPE_BYTE          6'h04
`define CMD_SEL_BYTE0          6'h10
`define CMD_SEL_BYTE1          6'h11
`define CMD_SEL_BYTE2          6'h12
`define CMD_SEL_BYTE3          6'h13
`define CMD_CKSUM_BYTE0        6'h14
`define CMD_PAD_LAST_BYTE      6'h2d
`define CMD_IDX_MAX            6'h3f

// ----------------------------------------------------------------------------
// Selection bits
// ----------------------------------------------------------------------------
`define SEL_ARP                0
`define SEL_DHCP_CLIENT        1
`define SEL_DHCP_SERVER        2
`define SEL_NETBIOS            3
`define SEL_W                  4

// ----------------------------------------------------------------------------
// Received frame offsets and values
// ----------------------------------------------------------------------------
`define FR_DST_LAST            6'h05
`define FR_ETYPE_HI            6'h0c
`define FR_ETYPE_LO            6'h0d
`define FR_IP_PROTO            6'h17
`define FR_UDP_DPORT_HI        6'h24
`define FR_UDP_DPORT_LO        6'h25
`define FR_IDX_MAX             6'h3f
`define BCAST_BYTE             8'hff
`define ETYPE_ARP              16'h0806
`define ETYPE_IPV4             16'h0800
`define IP_PROTO_UDP           8'h11
`define PORT_DHCP_CLIENT       16'h0044
`define PORT_DHCP_SERVER       16'h0043
`define PORT_NB_NAME           16'h0089
`define PORT_NB_DGRAM          16'h008a

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define REG_CTRL               12'h000
`define REG_STATUS             12'h004
`define REG_CAPS               12'h008
`define REG_FWD_COUNT          12'h00c
`define REG_DROP_COUNT         12'h010
`define CTRL_CLEAR_BIT         0
`define CTRL_OPT_LSB           1
`define CTRL_OPT_MSB           3
`define OPT_SUPPORT_RST        3'h7

// ----------------------------------------------------------------------------
// Verdict word and FIFO
// ----------------------------------------------------------------------------
`define VERDICT_W              6
`define FIFO_DEPTH             8
`define FIFO_AW                3

`endif

// [hw/broadcast_frame_filter.v]
// Broadcast frame filter with command parser, verdict FIFO and APB register file.
//
// Register access over APB and the address map were decided locally.
`include "bcast_filter_map.vh"

// ----------------------------------------------------------------------------
// Verdict FIFO
// ----------------------------------------------------------------------------
module verdict_fifo #(
    parameter WIDTH = `VERDICT_W,
    parameter DEPTH = `FIFO_DEPTH,
    parameter AW    = `FIFO_AW
) (
    input  wire             pclk,
    input  wire             presetn,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      count_q;
    reg             in_ready_q;
    reg             out_valid_q;
    wire            push;
    wire            pop;
    reg [AW:0]      count_d;

    assign push      = in_valid && in_ready_q;
    assign pop       = out_valid_q && out_ready;
    assign in_ready  = in_ready_q;
    assign out_valid = out_valid_q;
    assign out_data  = mem[rd_q];

    // Next occupancy; the flags are registered from it so both sides see flops.
    always @* begin
        count_d = count_q;
        if (push && !pop) count_d = count_q + 1'b1;
        else if (pop && !push) count_d = count_q - 1'b1;
    end

    // Pointers and flags.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q        <= {AW{1'b0}};
            rd_q        <= {AW{1'b0}};
            count_q     <= {(AW+1){1'b0}};
            in_ready_q  <= 1'b1;
            out_valid_q <= 1'b0;
        end else begin
            if (push) wr_q <= wr_q + 1'b1;
            if (pop) rd_q <= rd_q + 1'b1;
            count_q     <= count_d;
            in_ready_q  <= (count_d != DEPTH[AW:0]);
            out_valid_q <= (count_d != {(AW+1){1'b0}});
        end
    end

    // Storage has no reset; only entries below the count are ever read.
    always @(posedge pclk) begin
        if (push) mem[wr_q] <= in_data;
    end
endmodule // verdict_fifo

// ----------------------------------------------------------------------------
// Top level
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Command type 0x10 configures broadcast filtering.
// - After command, filter broadcasts by selection bits.
// - No type selected means drop all broadcasts.
// - Selection word in bytes 16 to 19.
// - Capabilities register advertises implemented type filters.
// - Bit one forwards type, zero drops it.
// - Every type needs all-ones destination address.
// - Bit 0 selects ARP, EtherType 0x0806.
// - ARP selection always implemented, never optional.
// - Bit 1: IPv4, UDP, destination port 68.
// - Bit 2: IPv4, UDP, destination port 67.
// - Bit 3: IPv4, UDP, port 137 or 138.
// - Unimplemented optional types blocked while filtering.
// - Accept good command, answer type 0x90.
module broadcast_frame_filter (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        cmd_valid,
    input  wire [7:0]  cmd_data,
    input  wire        cmd_last,
    input  wire        cmd_bad,
    output wire        resp_valid,
    output wire [7:0]  resp_type,
    input  wire        rx_valid,
    output wire        rx_ready,
    input  wire [7:0]  rx_data,
    input  wire        rx_last,
    output wire        verdict_valid,
    input  wire        verdict_ready,
    output wire [5:0]  verdict_data
);
    // Decode of a register offset; used by both the read and the write path.
    function [4:0] reg_hit;
        input [11:0] addr;
        begin
            reg_hit = {addr == `REG_DROP_COUNT, addr == `REG_FWD_COUNT, addr == `REG_CAPS,
                       addr == `REG_STATUS, addr == `REG_CTRL};
        end
    endfunction

    // ------------------------------------------------------------------------
    // Configuration state
    // ------------------------------------------------------------------------
    reg [`SEL_W-1:0] sel_q;
    reg              active_q;
    reg [2:0]        opt_q;
    reg [15:0]       fwd_cnt_q;
    reg [15:0]       drop_cnt_q;
    wire [`SEL_W-1:0] caps;

    // ARP is hard-wired present; the optional types follow the support mask.
    assign caps = {opt_q, 1'b1};

    // ------------------------------------------------------------------------
    // Command parser
    // ------------------------------------------------------------------------
    reg [5:0]  cidx_q;
    reg [7:0]  ctype_q;
    reg [31:0] cword_q;
    reg        resp_valid_q;
    reg [7:0]  resp_type_q;
    wire       cmd_apply;
    wire [7:0] ctype_now;

    // The type byte may be the same beat as the last one only in a runt packet.
    assign ctype_now = (cidx_q == `CMD_TYPE_BYTE) ? cmd_data : ctype_q;
    assign cmd_apply = cmd_valid && cmd_last && !cmd_bad &&
                       (ctype_now == `CMD_TYPE_ENABLE_BCAST) && (cidx_q >= `CMD_CKSUM_BYTE0);

    // Byte index, type byte and big-endian selection word capture.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cidx_q  <= 6'h00;
            ctype_q <= 8'h00;
            cword_q <= 32'h0000_0000;
        end else if (cmd_valid) begin
            if (cmd_last) cidx_q <= 6'h00;
            else if (cidx_q != `CMD_IDX_MAX) cidx_q <= cidx_q + 6'h01;
            if (cidx_q == `CMD_TYPE_BYTE) ctype_q <= cmd_data;
            if (cidx_q >= `CMD_SEL_BYTE0 && cidx_q <= `CMD_SEL_BYTE3) cword_q <= {cword_q[23:0], cmd_data};
        end
    end

    // Response strobe: one cycle after the last byte of an accepted command.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            resp_valid_q <= 1'b0;
            resp_type_q  <= 8'h00;
        end else begin
            resp_valid_q <= cmd_apply;
            if (cmd_apply) resp_type_q <= `RESP_TYPE_ENABLE_BCAST;
        end
    end

    // ------------------------------------------------------------------------
    // Frame classifier
    // ------------------------------------------------------------------------
    reg [5:0]  fidx_q;
    reg        dst_ok_q;
    reg [15:0] etype_q;
    reg [7:0]  proto_q;
    reg [15:0] dport_q;
    wire       rx_take;
    wire       dst_ok_d;
    wire [15:0] dport_d;
    wire       is_ipv4_udp;
    wire [`SEL_W-1:0] cls;
    wire [`SEL_W-1:0] allowed;
    wire       fwd;
    wire [`VERDICT_W-1:0] verdict_in;

    assign rx_take = rx_valid && rx_ready;

    // The last port byte may arrive on the closing beat, so fold it in here.
    assign dst_ok_d = (fidx_q <= `FR_DST_LAST) ? (dst_ok_q && rx_data == `BCAST_BYTE) : dst_ok_q;
    assign dport_d  = (fidx_q == `FR_UDP_DPORT_LO) ? {dport_q[15:8], rx_data} : dport_q;

    // Header fields sampled at fixed offsets; option-free IPv4 headers assumed.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fidx_q   <= 6'h00;
            dst_ok_q <= 1'b1;
            etype_q  <= 16'h0000;
            proto_q  <= 8'h00;
            dport_q  <= 16'h0000;
        end else if (rx_take) begin
            if (rx_last) begin
                fidx_q   <= 6'h00;
                dst_ok_q <= 1'b1;
                etype_q  <= 16'h0000;
                proto_q  <= 8'h00;
                dport_q  <= 16'h0000;
            end else begin
                if (fidx_q != `FR_IDX_MAX) fidx_q <= fidx_q + 6'h01;
                dst_ok_q <= dst_ok_d;
                if (fidx_q == `FR_ETYPE_HI) etype_q[15:8] <= rx_data;
                if (fidx_q == `FR_ETYPE_LO) etype_q[7:0] <= rx_data;
                if (fidx_q == `FR_IP_PROTO) proto_q <= rx_data;
                if (fidx_q == `FR_UDP_DPORT_HI) dport_q[15:8] <= rx_data;
                dport_q[7:0] <= dport_d[7:0];
            end
        end
    end

    // Type matching; a frame too short to reach a field never matches it.
    assign is_ipv4_udp = (etype_q == `ETYPE_IPV4) && (proto_q == `IP_PROTO_UDP);
    assign cls[`SEL_ARP]         = dst_ok_d && (etype_q == `ETYPE_ARP);
    assign cls[`SEL_DHCP_CLIENT] = dst_ok_d && is_ipv4_udp && (dport_d == `PORT_DHCP_CLIENT);
    assign cls[`SEL_DHCP_SERVER] = dst_ok_d && is_ipv4_udp && (dport_d == `PORT_DHCP_SERVER);
    assign cls[`SEL_NETBIOS]     = dst_ok_d && is_ipv4_udp &&
                                   (dport_d == `PORT_NB_NAME || dport_d == `PORT_NB_DGRAM);

    // A type passes only if selected and implemented; sel_q holds no reserved bits.
    assign allowed = sel_q & caps;
    assign fwd     = !dst_ok_d || !active_q || ((cls & allowed) != {`SEL_W{1'b0}});

    // Verdict word: forward flag, broadcast flag, class bits with at most one set.
    assign verdict_in = {fwd, dst_ok_d, cls};

    // ------------------------------------------------------------------------
    // Verdict path
    // ------------------------------------------------------------------------
    wire                  fifo_in_ready;
    wire                  fifo_out_valid;
    wire [`VERDICT_W-1:0] fifo_out_data;
    wire                  out_load;
    reg                   vout_valid_q;
    reg [`VERDICT_W-1:0]  vout_data_q;

    // Every byte stalls while the FIFO is full, so the source sees back-pressure at once.
    assign rx_ready = fifo_in_ready;

    verdict_fifo #(
        .WIDTH (`VERDICT_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_fifo (
        .pclk      (pclk),
        .presetn   (presetn),
        .in_valid  (rx_valid && rx_last),
        .in_ready  (fifo_in_ready),
        .in_data   (verdict_in),
        .out_valid (fifo_out_valid),
        .out_ready (out_load),
        .out_data  (fifo_out_data)
    );

    // Output stage keeps the verdict port on flops.
    assign out_load = !vout_valid_q || verdict_ready;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vout_valid_q <= 1'b0;
            vout_data_q  <= {`VERDICT_W{1'b0}};
        end else if (out_load) begin
            vout_valid_q <= fifo_out_valid;
            if (fifo_out_valid) vout_data_q <= fifo_out_data;
        end
    end

    // ------------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------------
    reg         pready_q;
    reg         pslverr_q;
    reg [31:0]  prdata_q;
    wire        setup;
    wire        wr_commit;
    wire [4:0]  hit_setup;
    wire        clear_req;

    // Answer comes in the first access cycle; read data is gathered during setup.
    assign setup     = psel && !penable;
    assign wr_commit = psel && penable && pready_q && pwrite && !pslverr_q;
    assign hit_setup = reg_hit(paddr);
    assign clear_req = wr_commit && hit_setup[0] && pwdata[`CTRL_CLEAR_BIT];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= setup;
            pslverr_q <= setup && (hit_setup == 5'h00);
            if (setup) begin
                case (1'b1)
                    hit_setup[0]: prdata_q <= {28'h000_0000, opt_q, 1'b0};
                    hit_setup[1]: prdata_q <= {24'h00_0000, sel_q, 3'h0, active_q};
                    hit_setup[2]: prdata_q <= {28'h000_0000, caps};
                    hit_setup[3]: prdata_q <= {16'h0000, fwd_cnt_q};
                    hit_setup[4]: prdata_q <= {16'h0000, drop_cnt_q};
                    default:      prdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Filter configuration: an accepted command wins over a software clear.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sel_q    <= {`SEL_W{1'b0}};
            active_q <= 1'b0;
            opt_q    <= `OPT_SUPPORT_RST;
        end else begin
            if (cmd_apply) begin
                sel_q    <= cword_q[`SEL_W-1:0];
                active_q <= 1'b1;
            end else if (clear_req) begin
                active_q <= 1'b0;
            end
            if (wr_commit && hit_setup[0]) opt_q <= pwdata[`CTRL_OPT_MSB:`CTRL_OPT_LSB];
        end
    end

    // Frame counters wrap; they count verdicts as they enter the FIFO.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fwd_cnt_q  <= 16'h0000;
            drop_cnt_q <= 16'h0000;
        end else if (rx_take && rx_last) begin
            if (fwd) fwd_cnt_q <= fwd_cnt_q + 16'h0001;
            else drop_cnt_q <= drop_cnt_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign prdata        = prdata_q;
    assign pready        = pready_q;
    assign pslverr       = pslverr_q;
    assign resp_valid    = resp_valid_q;
    assign resp_type     = resp_type_q;
    assign verdict_valid = vout_valid_q;
    assign verdict_data  = vout_data_q;
endmodule // broadcast_frame_filter

// [dv/bcast_filter_props.sv]
// Port checker for the broadcast frame filter, bound to its top module.
`include "bcast_filter_map.vh"
module bcast_filter_props (
    input logic        pclk,
    input logic        presetn,
    input logic        psel,
    input logic        penable,
    input logic        pwrite,
    input logic [11:0] paddr,
    input logic [31:0] pwdata,
    input logic [31:0] prdata,
    input logic        pready,
    input logic        pslverr,
    input logic        cmd_valid,
    input logic [7:0]  cmd_data,
    input logic        cmd_last,
    input logic        cmd_bad,
    input logic        resp_valid,
    input logic [7:0]  resp_type,
    input logic        rx_valid,
    input logic        rx_ready,
    input logic [7:0]  rx_data,
    input logic        rx_last,
    input logic        verdict_valid,
    input logic        verdict_ready,
    input logic [5:0]  verdict_data
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ------------------------------
    // Register bus
    // ------------------------------
    a_pready_after_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    a_pready_one_cycle: assert property (pready |=> !pready)
        else $error("pready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    // ------------------------------
    // Command and verdict streams
    // ------------------------------
    a_resp_type_code: assert property (resp_valid |-> resp_type == `RESP_TYPE_ENABLE_BCAST)
        else $error("wrong response type");
    a_resp_has_cause: assert property (resp_valid |-> $past(cmd_valid && cmd_last && !cmd_bad))
        else $error("response without good last byte");
    a_resp_single_pulse: assert property (resp_valid |=> !resp_valid)
        else $error("response pulse too long");
    a_verdict_held: assert property (verdict_valid && !verdict_ready |=> verdict_valid && $stable(verdict_data))
        else $error("verdict changed while stalled");
    a_unicast_passes: assert property (verdict_valid && !verdict_data[4] |-> verdict_data[5:0] == 6'h20)
        else $error("non broadcast frame classified or dropped");
    a_class_exclusive: assert property (verdict_valid |-> $onehot0(verdict_data[3:0]))
        else $error("more than one class flagged");
    // Main scenarios seen at least once.
    c_resp: cover property (resp_valid);
    c_drop: cover property (verdict_valid && verdict_ready && !verdict_data[5]);
    c_unmapped: cover property (pslverr);
    c_full: cover property (!rx_ready);
endmodule // bcast_filter_props

bind broadcast_frame_filter bcast_filter_props u_props (.*);

// [dv/mgmt_ctrl_model.sv]
// Management controller model: sends filter commands and takes verdicts.
module mgmt_ctrl_model (
    input wire logic  pclk,
    input wire logic  stall,
    output logic       cmd_valid,
    output logic [7:0] cmd_data,
    output logic       cmd_last,
    output logic       cmd_bad,
    output logic       verdict_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    // Idle values at time zero.
    initial begin
        cmd_valid = 1'b0;
        cmd_data = 8'h00;
        cmd_last = 1'b0;
        cmd_bad = 1'b0;
        verdict_ready = 1'b0;
    end
    // Registered ready, so a stall shows one cycle after it is asked for.
    always @(posedge pclk) begin
        verdict_ready <= !stall;
    end
    // One whole 46 byte packet; raw skips the masking to provoke the device.
    task automatic send_cmd(input logic [7:0] ty, input logic [31:0] s, input logic [3:0] caps,
                            input logic bad, input logic raw);
        logic [31:0] w;
        logic [7:0]  b;
        w = raw ? s : (s & {28'h0, caps});
        for (int i = 0; i < 46; i++) begin
            b = 8'h00;
            if (i == 4) b = ty;
            if (i >= 16 && i < 20) b = w[8 * (19 - i) +: 8];
            cmd_valid <= 1'b1;
            cmd_data <= b;
            cmd_last <= (i == 45);
            cmd_bad <= bad && (i == 45);
            @(posedge pclk);
        end
        cmd_valid <= 1'b0;
        cmd_last <= 1'b0;
        cmd_bad <= 1'b0;
        cmd_data <= ~b;
    endtask
endmodule // mgmt_ctrl_model

// [dv/broadcast_frame_filter_tb_top.sv]
// Self-checking testbench for the broadcast frame filter.
`include "bcast_filter_map.vh"
module broadcast_frame_filter_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, err, resp_valid, rx_ready, verdict_valid, verdict_ready;
    logic        cmd_valid, cmd_last, cmd_bad, rx_valid = 1'b0, rx_last = 1'b0;
    logic [7:0]  rx_data = 8'h00, resp_type, cmd_data;
    logic [5:0]  verdict_data;
    logic [15:0] seed = 16'd30906, js = 16'd30906;
    logic        hold = 1'b0, jit = 1'b0, stall = 1'b0, act = 1'b0;
    logic [3:0]  sel = 4'h0;
    logic [2:0]  mask = 3'h7;
    logic [3:0]  sels [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'hf};
    logic [5:0]  vq [$];
    logic [7:0]  rq [$];
    int          errors = 0, check_count = 0, cyc = 0, nf = 0, nd = 0;

    always #2 pclk = ~pclk;

    broadcast_frame_filter dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_last(cmd_last), .cmd_bad(cmd_bad),
        .resp_valid(resp_valid), .resp_type(resp_type), .rx_valid(rx_valid), .rx_ready(rx_ready),
        .rx_data(rx_data), .rx_last(rx_last), .verdict_valid(verdict_valid),
        .verdict_ready(verdict_ready), .verdict_data(verdict_data));
    mgmt_ctrl_model mc (
        .pclk(pclk), .stall(stall), .cmd_valid(cmd_valid), .cmd_data(cmd_data),
        .cmd_last(cmd_last), .cmd_bad(cmd_bad), .verdict_ready(verdict_ready));

    // ------------------------------
    // Helpers
    // ------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // One APB transfer; entered just after a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rchk(input string w, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(w, rd, e);
    endtask
    // Command through the model; the expected answer is noted after it is sent.
    task automatic cmd(input logic [7:0] ty, input logic [31:0] s, input logic bad, input logic raw);
        mc.send_cmd(ty, s, {mask, 1'b1}, bad, raw);
        if (ty == 8'h10 && !bad) begin
            rq.push_back(8'h90);
            act = 1'b1;
            sel = raw ? s[3:0] : (s[3:0] & {mask, 1'b1});
        end
        repeat (4) @(posedge pclk);
    endtask
    // A 40 byte frame; destination byte 5 is the lone odd byte when not broadcast.
    task automatic send_frame(input logic bc, input logic [15:0] et, input logic [7:0] pr,
                              input logic [15:0] dp);
        logic [7:0] b;
        logic [3:0] c;
        logic       ipu;
        ipu = et == 16'h0800 && pr == 8'd17;
        c = bc ? {ipu && (dp == 16'd137 || dp == 16'd138), ipu && dp == 16'd67,
                  ipu && dp == 16'd68, et == 16'h0806} : 4'h0;
        vq.push_back({!bc || !act || |(c & sel & {mask, 1'b1}), bc, c});
        if (vq[$][5]) nf++;
        else nd++;
        b = 8'h00;
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            b = seed[7:0];
            if (i < 6) b = (bc || i != 5) ? 8'hff : 8'hfe;
            if (i == 12) b = et[15:8];
            if (i == 13) b = et[7:0];
            if (i == 23) b = pr;
            if (i == 36) b = dp[15:8];
            if (i == 37) b = dp[7:0];
            rx_valid <= 1'b1;
            rx_data <= b;
            rx_last <= (i == 39);
            @(posedge pclk);
            while (rx_ready !== 1'b1) @(posedge pclk);
        end
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        rx_data <= ~b;
        @(posedge pclk);
    endtask
    task automatic run_set();
        send_frame(1'b1, 16'h0806, 8'h00, 16'h0000);
        send_frame(1'b1, 16'h0800, 8'd17, 16'd68);
        send_frame(1'b1, 16'h0800, 8'd17, 16'd67);
        send_frame(1'b1, 16'h0800, 8'd17, 16'd137);
        send_frame(1'b1, 16'h0800, 8'd17, 16'd138);
        send_frame(1'b1, 16'h0800, 8'd17, 16'd139);
        send_frame(1'b1, 16'h0800, 8'd6, 16'd68);
        send_frame(1'b0, 16'h0806, 8'h00, 16'h0000);
    endtask

    // ------------------------------
    // Watchers, stall pattern, timeout
    // ------------------------------
    // Results are taken at the edge that completes each handshake.
    always @(posedge pclk) begin
        if (verdict_valid === 1'b1 && verdict_ready === 1'b1) begin
            if (vq.size() == 0) check("verdict_extra", 32'h1, 32'h0);
            else check("verdict", {26'h0, verdict_data}, {26'h0, vq.pop_front()});
        end
        if (resp_valid === 1'b1) begin
            if (rq.size() == 0) check("resp_extra", 32'h1, 32'h0);
            else check("resp_type", {24'h0, resp_type}, {24'h0, rq.pop_front()});
        end
    end
    // Own generator here, so the data generator is never read mid-update.
    always @(posedge pclk) begin
        js <= lfsr(js);
        stall <= hold | (jit & js[0]);
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            finish_test();
        end
    end

    // ------------------------------
    // Main sequence
    // ------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk("caps", `REG_CAPS, 32'h0000000f);
        rchk("status", `REG_STATUS, 32'h0);
        rchk("ctrl", `REG_CTRL, 32'h0000000e);
        apb(1'b1, `REG_STATUS, 32'hffffffff);
        rchk("status_ro", `REG_STATUS, 32'h0);
        apb(1'b0, 12'h014, 32'h0);
        check("unmapped_err", {31'h0, err}, 32'h1);
        check("unmapped_data", rd, 32'h0);
        run_set();
        cmd(8'h10, 32'hf, 1'b1, 1'b0);
        cmd(8'h11, 32'hf, 1'b0, 1'b0);
        rchk("status_idle", `REG_STATUS, 32'h0);
        foreach (sels[k]) begin
            seed = lfsr(seed);
            cmd(8'h10, {seed, seed[11:0], sels[k]}, 1'b0, 1'b1);
            rchk("status_sel", `REG_STATUS, {24'h0, sels[k], 4'h1});
            run_set();
        end
        apb(1'b1, `REG_CTRL, 32'h0);
        mask = 3'h0;
        rchk("caps_masked", `REG_CAPS, 32'h1);
        run_set();
        apb(1'b1, `REG_CTRL, 32'hf);
        mask = 3'h7;
        act = 1'b0;
        apb(1'b0, `REG_STATUS, 32'h0);
        check("active_cleared", {31'h0, rd[0]}, 32'h0);
        run_set();
        cmd(8'h10, 32'h1, 1'b0, 1'b0);
        hold <= 1'b1;
        repeat (9) send_frame(1'b1, 16'h0806, 8'h00, 16'h0000);
        repeat (3) @(posedge pclk);
        check("rx_full", {31'h0, rx_ready}, 32'h0);
        hold <= 1'b0;
        jit <= 1'b1;
        run_set();
        while (vq.size() != 0 || rq.size() != 0) @(posedge pclk);
        rchk("fwd_count", `REG_FWD_COUNT, nf);
        rchk("drop_count", `REG_DROP_COUNT, nd);
        finish_test();
    end
endmodule // broadcast_frame_filter_tb_top
